// [period_timer_pkg.sv]
package period_timer_pkg;

  // Register bus geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [2:0] OFS_CONTROL = 3'h0;
  localparam logic [2:0] OFS_PERIOD = 3'h1;
  localparam logic [2:0] OFS_COUNT = 3'h2;
  localparam logic [2:0] OFS_STATUS = 3'h3;

  // Control register layout: bit 7 enable, bits 6:5 clock select, bits 4:0 mode
  typedef struct packed {
    logic on;
    logic [1:0] clk_sel;
    logic [4:0] mode;
  } timer_control_reg_s;

  // Status register bit positions
  localparam int STAT_ON_SYNC = 0;
  localparam int STAT_RUNNING = 1;
  localparam int STAT_ERS = 2;
  localparam int STAT_ARMED = 3;
  localparam int STAT_DONE = 4;

  // Reset values
  localparam timer_control_reg_s CONTROL_RESET = '{on: 1'b0, clk_sel: 2'h0, mode: 5'h00};
  localparam logic [7:0] PERIOD_RESET = 8'hFF;
  localparam logic [7:0] COUNT_RESET = 8'h00;

  // Mode classes in mode[4:3]
  localparam logic [1:0] CLASS_FREE = 2'h0;
  localparam logic [1:0] CLASS_ONESHOT = 2'h1;
  localparam logic [1:0] CLASS_MONO = 2'h2;

  // Low mode bits in mode[2:0]
  localparam logic [2:0] LOW_SW = 3'h0;
  localparam logic [2:0] LOW_RISE = 3'h1;
  localparam logic [2:0] LOW_FALL = 3'h2;
  localparam logic [2:0] LOW_ANY = 3'h3;
  localparam logic [2:0] LOW_EDGE_RISE = 3'h4;
  localparam logic [2:0] LOW_EDGE_FALL = 3'h5;
  localparam logic [2:0] LOW_LEVEL_LOW = 3'h6;
  localparam logic [2:0] LOW_LEVEL_HIGH = 3'h7;

  // Synchroniser depth in timer clocks
  localparam int SYNC_STAGES = 2;

endpackage

// [period_timer_mode_control.sv]
// What this block does
// - Software gate: count each timer clock while enable set, else hold.
// - Free-running: count equal to period returns to zero next timer clock.
// - Hardware gate: external signal also gates counting, high or low active.
// - Edge limit modes: chosen external edge resets the counter early.
// - After early edge reset, next period restarts two timer clocks later.
// - Level limit: counter held reset while external signal at reset level.
// - Level limit: external signal ignored while enable bit clear.
// - Level limit: reset on match or two clocks after reset level.
// - Level limit: resume after match or two clocks after release.
// - Software one shot: match resets counter and clears enable.
// - One shot: clearing enable pauses, setting resumes after the two-clock sync.
// - Edge start: after enable cleared, need enable and fresh edge.
// - Level one shot: clock after match clears enable, counter stops at zero.
// - Monostable: clock after match stops at zero; enable stays set in edge modes, level modes clear it.
// - Monostable low bits 001/010/011 rising/falling/any edge, 110/111 level; others reserved.
// - Enable and external signal synchronised over two timer clocks.
// - External triggers ignored while processor in debug mode.
//
// Local design decisions: the plain strobed port and the placing of the registers.
module period_timer_mode_control (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Register port
  input wire logic [period_timer_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [period_timer_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [period_timer_pkg::DATA_W-1:0] reg_rdata_out,
  // External signals
  input wire logic ext_reset_signal_in,
  input wire logic debug_mode_in,
  // Timer outputs
  output logic [7:0] count_value_out,
  output logic period_match_out,
  output logic running_out
);
  import period_timer_pkg::*;

  timer_control_reg_s control;
  logic [7:0] period_value;
  logic [7:0] count_value;
  logic [2:0] div_count;
  logic tick;
  logic on_meta;
  logic on_sync;
  logic ers_meta;
  logic ers_sync;
  logic ers_q;
  logic ers_prev;
  logic armed;
  logic done;
  logic rise;
  logic fall;
  logic [1:0] mclass;
  logic [2:0] low;
  logic match;
  logic run;
  logic zero_now;
  logic hold_zero;
  logic start_edge;
  logic hw_clear_on;
  logic next_armed;
  logic next_done;
  logic wr_control;
  logic wr_period;
  logic wr_count;

  // Divider mask for the selected timer clock rate
  // A tick fires when the low divider bits are all ones, so each rate
  // sees exactly one tick per divided period with no extra state.
  function automatic logic [2:0] div_mask(input logic [1:0] sel);
    case (sel)
      2'h0: div_mask = 3'h0;
      2'h1: div_mask = 3'h1;
      2'h2: div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  endfunction

  // Edge qualifier shared by start and reset decoding
  function automatic logic edge_hit(input logic [2:0] sel, input logic r, input logic f);
    case (sel)
      LOW_RISE, LOW_EDGE_RISE, LOW_LEVEL_LOW: edge_hit = r;
      LOW_FALL, LOW_EDGE_FALL, LOW_LEVEL_HIGH: edge_hit = f;
      LOW_ANY: edge_hit = r | f;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  // Level-reset decode shared by limit, one shot and monostable classes;
  // the high-reset encoding resets on a high level, all others on low
  function automatic logic at_reset_level(input logic [2:0] sel, input logic lvl);
    at_reset_level = (lvl == (sel == LOW_LEVEL_HIGH));
  endfunction

  assign wr_control = reg_write_in && (reg_addr_in == OFS_CONTROL);
  assign wr_period = reg_write_in && (reg_addr_in == OFS_PERIOD);
  assign wr_count = reg_write_in && (reg_addr_in == OFS_COUNT);
  assign mclass = control.mode[4:3];
  assign low = control.mode[2:0];
  assign tick = ((div_count & div_mask(control.clk_sel)) == div_mask(control.clk_sel));
  assign rise = ers_q & ~ers_prev;
  assign fall = ~ers_q & ers_prev;
  assign match = (count_value == period_value);

  // Timer clock divider; every slower rate is a one-cycle enable
  // Free-running from reset: after a rate change the first tick may come
  // early, which only shortens the first timer clock.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_count <= 3'h0;
    end else begin
      div_count <= div_count + 3'h1;
    end
  end

  // Two-stage sync on timer clock
  // Counting sees the enable two ticks late, while a read of the control
  // register returns the raw bit at once; status shows the synced copy.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      on_meta <= 1'b0;
      on_sync <= 1'b0;
      ers_meta <= 1'b0;
      ers_sync <= 1'b0;
    end else if (tick) begin
      on_meta <= control.on;
      on_sync <= on_meta;
      ers_meta <= ext_reset_signal_in;
      ers_sync <= ers_meta;
    end
  end

  // Debug freezes trigger
  // The previous copy keeps moving during debug, so a level change made
  // while frozen shows up as one edge once debug ends.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ers_q <= 1'b0;
      ers_prev <= 1'b0;
    end else if (tick && !debug_mode_in) begin
      ers_q <= ers_sync;
      ers_prev <= ers_q;
    end else if (tick) begin
      ers_prev <= ers_q;
    end
  end

  // Mode decode: run gate, forced zero, start edge, hardware enable clear
  // Reserved encodings fall to the default branches and never count,
  // so software that writes one simply sees a stopped timer.
  always_comb begin
    run = 1'b0;
    zero_now = 1'b0;
    hold_zero = 1'b0;
    start_edge = 1'b0;
    hw_clear_on = 1'b0;
    next_armed = armed;
    next_done = done;
    case (mclass)
      CLASS_FREE: begin
        case (low)
          LOW_SW: run = on_sync;
          LOW_RISE: run = on_sync & ers_q;
          LOW_FALL: run = on_sync & ~ers_q;
          LOW_LEVEL_LOW, LOW_LEVEL_HIGH: begin
            hold_zero = on_sync & at_reset_level(low, ers_q);
            run = on_sync & ~hold_zero;
          end
          default: begin
            run = on_sync;
            zero_now = on_sync & edge_hit(low, rise, fall);
          end
        endcase
      end
      CLASS_ONESHOT: begin
        if (low == LOW_SW) begin
          run = on_sync & ~done;
        end else begin
          start_edge = on_sync & ~armed & ~done & edge_hit(low, rise, fall);
          run = on_sync & (armed | start_edge) & ~done;
          if (low == LOW_EDGE_RISE || low == LOW_EDGE_FALL) begin
            zero_now = armed & on_sync & edge_hit(low, rise, fall);
          end else if (low == LOW_LEVEL_LOW || low == LOW_LEVEL_HIGH) begin
            hold_zero = at_reset_level(low, ers_q);
            run = run & ~hold_zero;
          end
        end
        if (run && match) begin
          hw_clear_on = 1'b1;
          next_done = 1'b1;
          next_armed = 1'b0;
        end else if (start_edge) begin
          next_armed = 1'b1;
        end
      end
      CLASS_MONO: begin
        case (low)
          LOW_RISE, LOW_FALL, LOW_ANY: begin
            start_edge = on_sync & ~armed & edge_hit(low, rise, fall);
            run = on_sync & (armed | start_edge);
            if (run && match) begin
              next_armed = 1'b0;
            end else if (start_edge) begin
              next_armed = 1'b1;
            end
          end
          LOW_LEVEL_LOW, LOW_LEVEL_HIGH: begin
            hold_zero = at_reset_level(low, ers_q);
            run = on_sync & ~done & ~hold_zero;
            if (run && match) begin
              hw_clear_on = 1'b1;
              next_done = 1'b1;
            end
          end
          default: run = 1'b0;
        endcase
      end
      default: run = 1'b0;
    endcase
    if (!on_sync) begin
      next_armed = 1'b0;
      next_done = 1'b0;
    end
  end

  // Edge-start and completion state, stepped on timer clocks
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      armed <= 1'b0;
      done <= 1'b0;
    end else if (tick) begin
      armed <= next_armed;
      done <= next_done;
    end
  end

  // Counter; a bus write to the count register takes priority
  // A loaded value above the period runs through 8'hFF and wraps before
  // the next match; software must keep count at or below period.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_value <= COUNT_RESET;
    end else if (wr_count) begin
      count_value <= reg_wdata_in;
    end else if (tick) begin
      if (zero_now || hold_zero) begin
        count_value <= 8'h00;
      end else if (run && match) begin
        count_value <= 8'h00;
      end else if (run) begin
        count_value <= count_value + 8'h01;
      end
    end
  end

  // Control register; a software write in the same cycle beats the hardware clear
  // A write in the very cycle a one shot ends keeps enable set, but done stays
  // set, so the timer stays stopped and the readback misses that completion.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      control <= CONTROL_RESET;
    end else if (wr_control) begin
      control <= timer_control_reg_s'(reg_wdata_in);
    end else if (tick && hw_clear_on) begin
      control.on <= 1'b0;
    end
  end

  // Period register, written only by software
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      period_value <= PERIOD_RESET;
    end else if (wr_period) begin
      period_value <= reg_wdata_in;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      case (reg_addr_in)
        OFS_CONTROL: reg_rdata_out <= control;
        OFS_PERIOD: reg_rdata_out <= period_value;
        OFS_COUNT: reg_rdata_out <= count_value;
        OFS_STATUS: begin
          reg_rdata_out <= 8'h00;
          reg_rdata_out[STAT_ON_SYNC] <= on_sync;
          reg_rdata_out[STAT_RUNNING] <= run;
          reg_rdata_out[STAT_ERS] <= ers_q;
          reg_rdata_out[STAT_ARMED] <= armed;
          reg_rdata_out[STAT_DONE] <= done;
        end
        default: reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // Registered timer outputs
  // The count output trails the internal counter by one cycle, so a match
  // pulse stands beside the count value that caused it.
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      period_match_out <= 1'b0;
      running_out <= 1'b0;
      count_value_out <= COUNT_RESET;
    end else begin
      period_match_out <= tick & run & match;
      running_out <= run;
      count_value_out <= count_value;
    end
  end

endmodule // period_timer_mode_control

// [period_timer_mode_control_sva.sv]
module period_timer_mode_control_sva
  import period_timer_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  // External and timer
  input wire logic ext_reset_signal_in,
  input wire logic debug_mode_in,
  input wire logic [7:0] count_value_out,
  input wire logic period_match_out,
  input wire logic running_out
);
  timer_control_reg_s ctrl_q;
  logic [7:0] period_q;
  logic reserved;

  // Control shadow goes stale when hardware clears enable, so it only qualifies; the period shadow is also compared against
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) ctrl_q <= CONTROL_RESET;
    else if (reg_write_in && reg_addr_in == OFS_CONTROL) ctrl_q <= timer_control_reg_s'(reg_wdata_in);
  end
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) period_q <= PERIOD_RESET;
    else if (reg_write_in && reg_addr_in == OFS_PERIOD) period_q <= reg_wdata_in;
  end
  assign reserved = ctrl_q.mode[4:3] == 2'h3 || (ctrl_q.mode[4:3] == CLASS_MONO &&
    ctrl_q.mode[2:0] inside {LOW_SW, LOW_EDGE_RISE, LOW_EDGE_FALL});

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  property p_rdata_idle;
    !$past(reg_read_in) |-> reg_rdata_out == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_match_value;
    period_match_out |-> count_value_out == period_q;
  endproperty
  a_match_value: assert property (p_match_value) else $error("match without equality");
  property p_count_bound;
    count_value_out <= period_q;
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("count passed period");
  property p_count_step;
    $changed(count_value_out) |-> count_value_out == $past(count_value_out) + 8'h01
      || count_value_out == 8'h00;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count jumped");
  property p_oneshot_stop;
    period_match_out && ctrl_q.mode == 5'h08 |->
      ##[1:3] (!running_out && count_value_out == 8'h00) [*4];
  endproperty
  a_oneshot_stop: assert property (p_oneshot_stop) else $error("one shot kept running");
  property p_mono_stop;
    period_match_out && ctrl_q.mode[4:3] == CLASS_MONO |-> ##[1:3] (count_value_out == 8'h00) [*4];
  endproperty
  a_mono_stop: assert property (p_mono_stop) else $error("monostable not parked at zero");
  property p_reserved_idle;
    reserved [*6] |-> !running_out && !period_match_out;
  endproperty
  a_reserved_idle: assert property (p_reserved_idle) else $error("reserved mode counts");
  property p_enable_sync;
    reg_write_in && reg_addr_in == OFS_CONTROL && reg_wdata_in[7] && !ctrl_q.on && !running_out
      |=> !running_out [*2];
  endproperty
  a_enable_sync: assert property (p_enable_sync) else $error("enable used unsynchronised");
endmodule // period_timer_mode_control_sva

// [ext_reset_source.sv]
module ext_reset_source (
  // Clock
  input wire logic clk_in,
  // Commanded level
  input wire logic level_in,
  // Line to timer
  output logic ext_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic held = 1'b0;
  // edges only on clock edges, spacing set by caller
  always @(posedge clk_in) held <= level_in;
  assign ext_out = held;
endmodule // ext_reset_source

// [period_timer_mode_control_tb.sv]
module period_timer_mode_control_tb;
  import period_timer_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [2:0] reg_addr_in = 3'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_write_in = 1'b0;
  logic reg_read_in = 1'b0;
  logic ext_level = 1'b0;
  logic debug_mode_in = 1'b0;
  logic ext_reset_signal_in;
  logic [7:0] reg_rdata_out;
  logic [7:0] count_value_out;
  logic period_match_out;
  logic running_out;
  logic [7:0] m;
  int fail_count = 0;
  int n_compared = 0;

  always #12.5 ref_clk_in = ~ref_clk_in;

  ext_reset_source u_src (.clk_in(ref_clk_in), .level_in(ext_level), .ext_out(ext_reset_signal_in));
  period_timer_mode_control DUT (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .ext_reset_signal_in(ext_reset_signal_in), .debug_mode_in(debug_mode_in),
    .count_value_out(count_value_out), .period_match_out(period_match_out),
    .running_out(running_out));

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rd(input string name, input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_read_in <= 1'b0;
    #1;
    chk(name, exp, reg_rdata_out);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic wait_match(input int bound);
    for (int i = 0; i < bound; i++) begin
      @(posedge ref_clk_in);
      #1;
      if (period_match_out === 1'b1) return;
    end
    chk("period match", 8'h01, 8'h00);
    final_report();
  endtask

  initial begin
    wt(4);
    rstn_in <= 1'b1;
    rd("control", OFS_CONTROL, CONTROL_RESET);
    rd("period", OFS_PERIOD, PERIOD_RESET);
    rd("count", OFS_COUNT, COUNT_RESET);
    wr(3'h5, 8'hA5);
    rd("unmapped", 3'h5, 8'h00);
    wr(OFS_PERIOD, 8'h03);
    wr(OFS_CONTROL, 8'h80);
    wait_match(20);
    m = 8'h00;
    repeat (40) begin
      @(posedge ref_clk_in);
      #1;
      m = m + {7'h00, period_match_out};
    end
    chk("match count", 8'h0A, m);
    wr(OFS_CONTROL, 8'h00);
    wt(6);
    m = count_value_out;
    wt(8);
    chk("hold", m, count_value_out);
    for (int k = 1; k < 3; k++) begin
      ext_level <= (k == 2);
      wr(OFS_COUNT, 8'h00);
      wr(OFS_CONTROL, 8'h80 | k[7:0]);
      wt(10);
      chk("gate stop", 8'h00, count_value_out);
      ext_level <= (k == 1);
      wt(10);
      chk("gate run", 8'h01, {7'h00, running_out});
      wr(OFS_CONTROL, 8'h00);
      wt(6);
    end
    wr(OFS_PERIOD, 8'hFF);
    // Edges stay well over six timer clocks apart
    for (int k = 3; k < 6; k++) begin
      ext_level <= 1'b0;
      wr(OFS_COUNT, 8'h00);
      wr(OFS_CONTROL, 8'h80 | k[7:0]);
      wt(30);
      ext_level <= 1'b1;
      wt(8);
      chk("rise reset", {7'h00, k != 5}, {7'h00, count_value_out < 8'h0C});
      wt(30);
      ext_level <= 1'b0;
      wt(8);
      chk("fall reset", {7'h00, k != 4}, {7'h00, count_value_out < 8'h0C});
      wr(OFS_CONTROL, 8'h00);
    end
    wr(OFS_COUNT, 8'h00);
    wr(OFS_CONTROL, 8'h84);
    wt(30);
    debug_mode_in <= 1'b1;
    ext_level <= 1'b1;
    wt(8);
    chk("debug ignore", 8'h00, {7'h00, count_value_out < 8'h0C});
    debug_mode_in <= 1'b0;
    wr(OFS_CONTROL, 8'h87);
    wt(10);
    chk("level held", 8'h00, count_value_out);
    ext_level <= 1'b0;
    wt(10);
    chk("level run", 8'h01, {7'h00, running_out});
    wr(OFS_CONTROL, 8'h07);
    wt(6);
    m = count_value_out;
    ext_level <= 1'b1;
    wt(8);
    chk("level off", m, count_value_out);
    wr(OFS_COUNT, 8'h00);
    wr(OFS_PERIOD, 8'h04);
    wr(OFS_CONTROL, 8'h88);
    wait_match(20);
    wt(6);
    rd("oneshot control", OFS_CONTROL, 8'h08);
    chk("oneshot count", 8'h00, count_value_out);
    for (int k = 1; k < 4; k++) begin
      ext_level <= (k == 2);
      wr(OFS_CONTROL, 8'h90 | k[7:0]);
      wt(8);
      ext_level <= (k != 2);
      wait_match(30);
      wt(6);
      rd("mono control", OFS_CONTROL, 8'h90 | k[7:0]);
      chk("mono count", 8'h00, count_value_out);
    end
    wr(OFS_CONTROL, 8'h94);
    ext_level <= 1'b0;
    wt(12);
    chk("reserved run", 8'h00, {7'h00, running_out});
    ext_level <= 1'b1;
    wr(OFS_CONTROL, 8'h96);
    wait_match(30);
    wt(6);
    rd("level mono control", OFS_CONTROL, 8'h16);
    chk("level mono count", 8'h00, count_value_out);
    ext_level <= 1'b0;
    wr(OFS_CONTROL, 8'h89);
    wt(8);
    chk("edge oneshot wait", 8'h00, {7'h00, running_out});
    ext_level <= 1'b1;
    wait_match(30);
    wt(6);
    rd("edge oneshot control", OFS_CONTROL, 8'h09);
    chk("edge oneshot count", 8'h00, count_value_out);
    final_report();
  end
endmodule // period_timer_mode_control_tb

bind period_timer_mode_control period_timer_mode_control_sva u_sva (.ref_clk_in(ref_clk_in),
  .rstn_in(rstn_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
  .ext_reset_signal_in(ext_reset_signal_in), .debug_mode_in(debug_mode_in),
  .count_value_out(count_value_out), .period_match_out(period_match_out),
  .running_out(running_out));
